// ---- trigger_frame_readout.sv ----
// Purpose: capture trigger frames per probe and stream them back as a binary block
// Assumes: sample and command inputs come from logic on sys_clk
// Notes: text formatting of list queries is left to the host side firmware
`include "trigger_frame_readout_regs.svh"
`default_nettype none

module trigger_frame_readout
  import trigger_frame_readout_pkg::*;
#(
  parameter int PROBES = 2,
  parameter int MAXLEN = 1024,
  parameter int SLOW_CYCLES = `SLOW_CYCLES,
  parameter int WAIT_UNIT_CYCLES = `WAIT_UNIT_CYCLES,
  parameter int GAP_LONG_CYCLES = `GAP_LONG_CYCLES,
  parameter int GAP_SHORT_CYCLES = `GAP_SHORT_CYCLES,
  localparam int PW = (PROBES > 1) ? $clog2(PROBES) : 1,
  localparam int IW = $clog2(MAXLEN + 1)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] opMode,
  input wire logic [PROBES-1:0] cmdArm,
  input wire logic [PROBES-1:0] cmdClear,
  input wire logic [PROBES-1:0] cmdTrigger,
  input wire logic [IW-1:0] frameLength,
  input wire logic [PROBES-1:0] probeDefined,
  input wire logic [PROBES-1:0] probeUp,
  input wire logic [PROBES-1:0] calValid,
  input wire logic [PROBES-1:0][31:0] ifSerial,
  input wire logic [PROBES-1:0][31:0] probeSerial,
  input wire logic sampleValid,
  input wire logic [PW-1:0] sampleProbe,
  input wire logic [31:0] fieldX,
  input wire logic [31:0] fieldY,
  input wire logic [31:0] fieldZ,
  input wire logic [31:0] fieldMag,
  input wire logic [15:0] rssiX,
  input wire logic [15:0] rssiY,
  input wire logic [15:0] rssiZ,
  input wire logic lfUpdate,
  input wire logic burstStart,
  input wire logic [31:0] accelX,
  input wire logic [31:0] accelY,
  input wire logic [31:0] accelZ,
  input wire logic [31:0] tempC,
  input wire logic [31:0] supplyV,
  input wire logic [PROBES-1:0][31:0] avgX,
  input wire logic [PROBES-1:0][31:0] avgY,
  input wire logic [PROBES-1:0][31:0] avgZ,
  input wire logic [PROBES-1:0][31:0] avgMag,
  input wire logic queryValid,
  input wire trigger_frame_readout_pkg::query_t queryKind,
  input wire logic [PROBES-1:0] querySelect,
  input wire logic [7:0] queryTimeout,
  output logic queryReady,
  output logic [7:0] outData,
  output logic outValid,
  input wire logic outReady,
  output trigger_frame_readout_pkg::cap_t [PROBES-1:0] captureState,
  output logic [PROBES-1:0] calReady,
  output logic [PROBES-1:0] rawReady,
  output logic [PROBES-1:0][15:0] slowCount,
  output logic [4:0][31:0] slowLatest,
  output logic [31:0] burstGap
);
  import trigger_frame_readout_pkg::*;

  localparam int MW = 1 + 48 + 128;
  localparam int AW = PW + IW;

  if (PROBES < 1 || MAXLEN < 2 || SLOW_CYCLES < 2 || WAIT_UNIT_CYCLES < 2) begin : g_check
    $error("bad parameters");
  end

  // ****
  // helpers
  // ****
  function automatic logic [31:0] u16ToFloat(input logic [15:0] v);
    logic [4:0] msb;
    logic [38:0] shifted;
    msb = 5'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        msb = 5'(i);
      end
    end
    shifted = 39'(v) << (5'd23 - msb);
    if (v == 16'h0) begin
      return `FLOAT_ZERO;
    end
    return {1'b0, 8'(8'd127 + 8'(msb)), shifted[22:0]};
  endfunction : u16ToFloat

  function automatic logic [PW-1:0] lowestBit(input logic [PROBES-1:0] m);
    logic [PW-1:0] idx;
    idx = '0;
    for (int i = PROBES - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = PW'(i);
      end
    end
    return idx;
  endfunction : lowestBit

  // ****
  // capture state per probe
  // ****
  cap_t capState [PROBES];
  logic [IW-1:0] wrIdx [PROBES];
  logic [PROBES-1:0] indicator;
  logic [PROBES-1:0] autoClear;
  logic [PROBES-1:0] autoArm;
  logic [PROBES-1:0] dataOk;
  logic [IW-1:0] chunkCount [PROBES];
  logic lfMode;
  logic storeSample;
  logic next_ind;
  logic [MW-1:0] rdData;
  logic slowTick;
  logic [31:0] slowCnt;
  logic [PW-1:0] curP;
  logic [IW-1:0] sIdx;
  logic rdEn;

  assign lfMode = (opMode == 3'h0) || (opMode == 3'h2) || (opMode == 3'h3);
  assign storeSample = sampleValid && (capState[sampleProbe] == CAP_TRIGGERED)
      && (wrIdx[sampleProbe] < frameLength);
  // a toggle either follows new low-frequency data or opens a new burst
  assign next_ind = indicator[sampleProbe]
      ^ (lfMode ? lfUpdate : burstStart);

  for (genvar p = 0; p < PROBES; p++) begin : g_probe
    assign dataOk[p] = probeDefined[p] && probeUp[p] && calValid[p]
        && (capState[p] == CAP_FINISHED);
    assign chunkCount[p] = dataOk[p] ? wrIdx[p] : '0;

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        capState[p] <= CAP_IDLE;
        wrIdx[p] <= '0;
      end else if (cmdClear[p] || autoClear[p]) begin
        capState[p] <= CAP_IDLE;
      end else if (cmdArm[p] || autoArm[p]) begin
        capState[p] <= CAP_ARMED;
        wrIdx[p] <= '0;
      end else begin
        case (capState[p])
          CAP_ARMED: begin
            if (cmdTrigger[p]) begin
              capState[p] <= (frameLength == '0) ? CAP_FINISHED : CAP_TRIGGERED;
            end
          end
          CAP_TRIGGERED: begin
            if (storeSample && sampleProbe == PW'(p)) begin
              wrIdx[p] <= IW'(wrIdx[p] + 1'b1);
              if (IW'(wrIdx[p] + 1'b1) >= frameLength) begin
                capState[p] <= CAP_FINISHED;
              end
            end
          end
          default: ;
        endcase
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        indicator[p] <= 1'b0;
      end else if (sampleValid && sampleProbe == PW'(p)) begin
        indicator[p] <= next_ind;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst || cmdArm[p] || autoArm[p]) begin
        slowCount[p] <= 16'h0;
      end else if (slowTick && capState[p] == CAP_TRIGGERED) begin
        slowCount[p] <= slowCount[p] + 16'h1;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        captureState[p] <= CAP_IDLE;
        calReady[p] <= 1'b0;
        rawReady[p] <= 1'b0;
      end else begin
        captureState[p] <= capState[p];
        calReady[p] <= dataOk[p];
        rawReady[p] <= probeDefined[p] && probeUp[p]
            && (capState[p] == CAP_FINISHED);
      end
    end
  end

  frame_store #(
    .WIDTH(MW),
    .DEPTH(PROBES * (2 ** IW)),
    .AW(AW)
  ) u_store (
    .sys_clk(sys_clk),
    .we(storeSample),
    .waddr({sampleProbe, wrIdx[sampleProbe]}),
    .wdata({next_ind, rssiX, rssiY, rssiZ, fieldX, fieldY, fieldZ, fieldMag}),
    .re(rdEn),
    .raddr({curP, sIdx}),
    .rdata(rdData)
  );

  // ****
  // slow series and burst gap
  // ****
  // slow samples run off their own divider, so counts per frame may differ by one
  assign slowTick = (slowCnt == 32'(SLOW_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (rst || slowTick) begin
      slowCnt <= 32'h0;
    end else begin
      slowCnt <= slowCnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slowLatest <= '0;
    end else if (slowTick) begin
      // acceleration arrives already scaled in g, sign kept so up reads plus one
      slowLatest <= {supplyV, tempC, accelZ, accelY, accelX};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      burstGap <= 32'h0;
    end else begin
      burstGap <= lfMode ? 32'h0 : (opMode == 3'h1 || opMode == 3'h5) ?
          32'(GAP_LONG_CYCLES) : 32'(GAP_SHORT_CYCLES);
    end
  end

  // ****
  // readout sequencer
  // ****
  fsm_t state;
  query_t kind;
  logic [PROBES-1:0] selMask;
  logic [PROBES-1:0] rearm;
  logic [1:0] headIdx;
  logic [2:0] series;
  logic [31:0] wordReg;
  logic [2:0] bytesLeft;
  logic [7:0] waitLeft;
  logic [31:0] unitCnt;
  logic [31:0] totalBytes;
  logic [31:0] headWord;
  logic [31:0] seriesWord;
  logic [31:0] avgWord;
  logic emitIdle;
  logic allDone;
  logic bufReady;
  logic pushFire;
  logic [PROBES-1:0] lowMask;

  assign emitIdle = (bytesLeft == 3'h0);
  assign pushFire = !emitIdle && bufReady;
  assign rdEn = (state == S_READ);
  assign allDone = ((dataOk & selMask) == selMask);
  assign autoClear = (state == S_CLR) ? rearm : '0;
  assign autoArm = (state == S_ARM) ? rearm : '0;
  assign lowMask = PROBES'(1) << lowestBit(selMask);

  always_comb begin
    totalBytes = 32'h0;
    for (int i = 0; i < PROBES; i++) begin
      if (selMask[i]) begin
        totalBytes = totalBytes + `HEAD_BYTES + 32'(chunkCount[i]) * `SAMPLE_BYTES;
      end
    end
  end

  always_comb begin
    case (headIdx)
      2'h0: headWord = probeDefined[curP] ? ifSerial[curP] : 32'h0;
      2'h1: headWord = (probeDefined[curP] && probeUp[curP]) ? probeSerial[curP] : 32'h0;
      default: headWord = 32'(chunkCount[curP]);
    endcase
  end

  always_comb begin
    case (series)
      3'h0: seriesWord = rdData[127:96];
      3'h1: seriesWord = rdData[95:64];
      3'h2: seriesWord = rdData[63:32];
      3'h3: seriesWord = rdData[31:0];
      3'h4: seriesWord = rdData[176] ? `FLOAT_ONE : `FLOAT_ZERO;
      3'h5: seriesWord = u16ToFloat(rdData[175:160]);
      3'h6: seriesWord = u16ToFloat(rdData[159:144]);
      default: seriesWord = u16ToFloat(rdData[143:128]);
    endcase
  end

  always_comb begin
    case (headIdx)
      2'h0: avgWord = avgX[curP];
      2'h1: avgWord = avgY[curP];
      2'h2: avgWord = avgZ[curP];
      default: avgWord = avgMag[curP];
    endcase
    if (!dataOk[curP]) begin
      avgWord = `FLOAT_NAN;
    end
  end

  // each word leaves low byte first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= S_IDLE;
      queryReady <= 1'b1;
      selMask <= '0;
      rearm <= '0;
      curP <= '0;
      bytesLeft <= 3'h0;
    end else begin
      if (pushFire) begin
        wordReg <= {8'h0, wordReg[31:8]};
        bytesLeft <= bytesLeft - 3'h1;
      end
      case (state)
        S_IDLE: begin
          if (queryValid && queryReady) begin
            queryReady <= 1'b0;
            kind <= queryKind;
            selMask <= querySelect;
            waitLeft <= (queryKind == Q_WAIT_BINARY) ? queryTimeout : 8'h0;
            unitCnt <= 32'h0;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (allDone || waitLeft == 8'h0) begin
            rearm <= (kind == Q_WAIT_BINARY && allDone) ? selMask : '0;
            curP <= lowestBit(selMask);
            headIdx <= 2'h0;
            state <= S_COUNT;
          end else if (unitCnt == 32'(WAIT_UNIT_CYCLES - 1)) begin
            unitCnt <= 32'h0;
            waitLeft <= waitLeft - 8'h1;
          end else begin
            unitCnt <= unitCnt + 32'h1;
          end
        end
        S_COUNT: begin
          if (kind == Q_AVERAGE) begin
            state <= S_AVG;
          end else if (emitIdle) begin
            // only the low byte of the total fits in the leading count
            wordReg <= {24'h0, totalBytes[7:0]};
            bytesLeft <= 3'h1;
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (selMask == '0) begin
            state <= S_CR;
          end else begin
            curP <= lowestBit(selMask);
            selMask <= selMask & ~lowMask;
            headIdx <= 2'h0;
            state <= S_HEAD;
          end
        end
        S_HEAD: begin
          if (emitIdle) begin
            wordReg <= headWord;
            bytesLeft <= 3'h4;
            headIdx <= headIdx + 2'h1;
            if (headIdx == `HEAD_WORDS) begin
              series <= 3'h0;
              sIdx <= '0;
              state <= (chunkCount[curP] == '0) ? S_NEXT : S_READ;
            end
          end
        end
        S_READ: begin
          state <= S_LOAD;
        end
        S_LOAD: begin
          if (emitIdle) begin
            wordReg <= seriesWord;
            bytesLeft <= 3'h4;
            state <= S_READ;
            if (IW'(sIdx + 1'b1) == chunkCount[curP]) begin
              sIdx <= '0;
              series <= series + 3'h1;
              if (series == `LAST_SERIES) begin
                state <= S_NEXT;
              end
            end else begin
              sIdx <= IW'(sIdx + 1'b1);
            end
          end
        end
        S_AVG: begin
          if (emitIdle) begin
            wordReg <= avgWord;
            bytesLeft <= 3'h4;
            headIdx <= headIdx + 2'h1;
            if (headIdx == `LAST_AVG) begin
              state <= S_CR;
            end
          end
        end
        S_CR: begin
          if (emitIdle) begin
            wordReg <= {24'h0, `BYTE_CR};
            bytesLeft <= 3'h1;
            state <= S_LF;
          end
        end
        S_LF: begin
          if (emitIdle) begin
            wordReg <= {24'h0, `BYTE_LF};
            bytesLeft <= 3'h1;
            if (rearm == '0) begin
              queryReady <= 1'b1;
              state <= S_IDLE;
            end else begin
              state <= S_CLR;
            end
          end
        end
        S_CLR: begin
          state <= S_ARM;
        end
        S_ARM: begin
          rearm <= '0;
          queryReady <= 1'b1;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****
  // two-entry output buffer
  // ****
  // a receiver stall fills the second entry, then holds the sequencer
  logic [7:0] spare;
  logic spareValid;
  logic popFire;

  assign bufReady = !spareValid;
  assign popFire = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outData <= 8'h0;
      outValid <= 1'b0;
      spare <= 8'h0;
      spareValid <= 1'b0;
    end else begin
      case ({pushFire, popFire})
        2'b10: begin
          if (!outValid) begin
            outData <= wordReg[7:0];
            outValid <= 1'b1;
          end else begin
            spare <= wordReg[7:0];
            spareValid <= 1'b1;
          end
        end
        2'b01: begin
          outData <= spare;
          outValid <= spareValid;
          spareValid <= 1'b0;
        end
        2'b11: begin
          outData <= wordReg[7:0];
        end
        default: ;
      endcase
    end
  end

endmodule : trigger_frame_readout

`default_nettype wire

// ---- trigger_frame_readout_regs.svh ----
// Purpose: constants for the trigger frame readout block
// Assumes: 100 MHz system clock
// Notes: timing counts derive from the printed times
// Function
// - each stored sample carries a 0/1 burst indicator
// - modes 0,2,3: toggle marks new low-frequency samples
// - other modes: toggle marks burst, gap 3.9/0.8 ms
// - calibrated data invalid unless up, calibrated, finished
// - binary reply: leading byte count, trailing CR LF
// - one chunk per selected probe, little endian
// - interface serial first; undefined probe gives zeros
// - probe serial next; off probe gives zeros
// - sample count next; zero without calibration or finish
// - five float series: x, y, z, magnitude, indicator
// - three signal strength series as float words
// - waiting query clears then arms after full data
// - waiting query blocks up to timeout seconds
// - average query returns four values x,y,z,magnitude
// - raw readings need no calibration, need finish
// - slow series sampled at 1.3 kHz independently
// - acceleration reported in g, up is plus one
// - temperature and voltage follow slow series behaviour
// - capture has idle, armed, triggered, finished states
`ifndef TRIGGER_FRAME_READOUT_REGS_SVH
`define TRIGGER_FRAME_READOUT_REGS_SVH

`define CLK_HZ 100000000
`define SLOW_RATE_HZ 1300
`define SLOW_CYCLES (`CLK_HZ / `SLOW_RATE_HZ)
`define WAIT_UNIT_CYCLES `CLK_HZ
`define GAP_LONG_US 3900
`define GAP_SHORT_US 800
`define GAP_LONG_CYCLES (`GAP_LONG_US * (`CLK_HZ / 1000000))
`define GAP_SHORT_CYCLES (`GAP_SHORT_US * (`CLK_HZ / 1000000))
`define FLOAT_NAN 32'h7fc00000
`define FLOAT_ONE 32'h3f800000
`define FLOAT_ZERO 32'h00000000
`define BYTE_CR 8'h0d
`define BYTE_LF 8'h0a
`define HEAD_WORDS 2'h2
`define HEAD_BYTES 32'h0000000c
`define SAMPLE_BYTES 32'h00000020
`define LAST_SERIES 3'h7
`define LAST_AVG 2'h3

`endif

// ---- trigger_frame_readout_pkg.sv ----
// Purpose: types shared by the trigger frame readout block
// Assumes: nothing beyond the header constants
// Notes: capture and readout states are gray coded
`default_nettype none

package trigger_frame_readout_pkg;

  typedef enum logic [1:0] {
    CAP_IDLE = 2'h0,
    CAP_ARMED = 2'h1,
    CAP_TRIGGERED = 2'h3,
    CAP_FINISHED = 2'h2
  } cap_t;

  typedef enum logic [1:0] {
    Q_BINARY = 2'h0,
    Q_WAIT_BINARY = 2'h1,
    Q_AVERAGE = 2'h2
  } query_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_WAIT = 4'h1,
    S_COUNT = 4'h3,
    S_NEXT = 4'h2,
    S_HEAD = 4'h6,
    S_READ = 4'h7,
    S_LOAD = 4'h5,
    S_CR = 4'h4,
    S_LF = 4'hc,
    S_CLR = 4'hd,
    S_ARM = 4'hf,
    S_AVG = 4'he
  } fsm_t;

endpackage : trigger_frame_readout_pkg

`default_nettype wire

// ---- frame_store.sv ----
// Purpose: sample memory for captured trigger frames
// Assumes: one write and one read port on one clock
// Notes: read data come out of a register one cycle after re
`default_nettype none

module frame_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : frame_store

`default_nettype wire

// ---- trigger_frame_readout_props.sv ----
// Purpose: port-level checks on the trigger frame readout block
// Assumes: one clock domain, synchronous active high reset
// Notes: state flags lag the internal state by one cycle, a command by two
`default_nettype none
module trigger_frame_readout_props
  import trigger_frame_readout_pkg::*;
#(
  parameter int PROBES = 2,
  parameter int GAP_LONG_CYCLES = 390000,
  parameter int GAP_SHORT_CYCLES = 80000
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] opMode,
  input wire logic [PROBES-1:0] cmdArm,
  input wire logic [PROBES-1:0] cmdClear,
  input wire logic queryValid,
  input wire trigger_frame_readout_pkg::query_t queryKind,
  input wire logic queryReady,
  input wire logic outValid,
  input wire logic [7:0] outData,
  input wire logic outReady,
  input wire trigger_frame_readout_pkg::cap_t [PROBES-1:0] captureState,
  input wire logic [PROBES-1:0] calReady,
  input wire logic [PROBES-1:0] rawReady,
  input wire logic [PROBES-1:0][15:0] slowCount,
  input wire logic [31:0] burstGap
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_take_bin;
    queryValid && queryReady && queryKind == Q_BINARY;
  endsequence
  sequence s_first_byte;
    ##[2:5] outValid;
  endsequence
  sequence s_arm_req;
    cmdArm[0] && !cmdClear[0];
  endsequence
  a_first_byte: assert property (s_take_bin |-> s_first_byte)
    else $error("late reply");
  a_take_busy: assert property (queryValid && queryReady |=> !queryReady)
    else $error("ready held");
  a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("byte changed");
  a_gap_long: assert property (!$past(rst) && $past(opMode) inside {1, 5}
    |-> burstGap == GAP_LONG_CYCLES)
    else $error("long gap");
  a_gap_short: assert property (!$past(rst) && $past(opMode) inside {4, 6, 7}
    |-> burstGap == GAP_SHORT_CYCLES)
    else $error("short gap");
  a_gap_none: assert property (!$past(rst) && $past(opMode) inside {0, 2, 3}
    |-> burstGap == 0)
    else $error("gap in mode");
  a_clear_idle: assert property (cmdClear[0] |-> ##[1:2] captureState[0] == CAP_IDLE)
    else $error("no idle");
  a_arm_state: assert property (s_arm_req |-> ##[1:2] captureState[0] == CAP_ARMED)
    else $error("no armed");
  a_arm_count: assert property (s_arm_req |-> ##[1:2] slowCount[0] == 16'h0)
    else $error("count kept");
  a_cal_raw: assert property (calReady[0] |-> rawReady[0] && captureState[0] == CAP_FINISHED)
    else $error("cal unfinished");
endmodule : trigger_frame_readout_props
`default_nettype wire

// ---- host_model.sv ----
// Purpose: host side sink of the binary byte stream
// Assumes: bytes leave on outValid and outReady at a rising edge
// Notes: stalls 3 of every 16 cycles so the two-entry buffer fills
`default_nettype none
module host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic outValid,
  input wire logic [7:0] outData,
  output logic outReady
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx[$];
  logic [3:0] phase = 4'h0;
  initial outReady = 1'b0;
  always @(posedge sys_clk) begin
    if (!rst && outValid && outReady) rx.push_back(outData);
    phase = phase + 4'h1;
    #1;
    outReady = (phase < 4'hd);
  end
endmodule : host_model
`default_nettype wire

// ---- trigger_frame_readout_tb_top.sv ----
// Purpose: self-checking bench for the trigger frame readout block
// Assumes: probe 0 defined, probe 1 undefined
// Notes: short slow and wait counts keep the run brief
`default_nettype none
module trigger_frame_readout_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import trigger_frame_readout_pkg::*;
  localparam int LEN = 3;
  localparam int GL = 390;
  localparam int GS = 80;
  logic sys_clk, rst, sampleValid, lfUpdate, burstStart, queryValid, queryReady, outValid;
  logic outReady;
  logic [2:0] opMode;
  logic [1:0] cmdArm, cmdClear, cmdTrigger, probeDefined, probeUp, calValid, querySelect;
  logic [1:0] calReady, rawReady;
  logic [3:0] frameLength;
  logic [1:0][31:0] ifSerial, probeSerial, avgX, avgY, avgZ, avgMag;
  logic [0:0] sampleProbe;
  logic [31:0] fieldX, fieldY, fieldZ, fieldMag, accelX, accelY, accelZ, tempC, supplyV;
  logic [31:0] burstGap, lfsr, r;
  logic [15:0] rssiX, rssiY, rssiZ;
  query_t queryKind;
  logic [7:0] queryTimeout, outData;
  cap_t [1:0] captureState;
  logic [1:0][15:0] slowCount;
  logic [4:0][31:0] slowLatest;
  logic [7:0] expQ[$];
  logic [31:0] series[8][$];
  logic ind;
  int n_mismatch, compares;
  trigger_frame_readout #(.PROBES(2), .MAXLEN(15), .SLOW_CYCLES(8), .WAIT_UNIT_CYCLES(20),
    .GAP_LONG_CYCLES(GL), .GAP_SHORT_CYCLES(GS)) i_dut (.sys_clk, .rst, .opMode, .cmdArm,
    .cmdClear, .cmdTrigger, .frameLength, .probeDefined, .probeUp, .calValid, .ifSerial,
    .probeSerial, .sampleValid, .sampleProbe, .fieldX, .fieldY, .fieldZ, .fieldMag, .rssiX,
    .rssiY, .rssiZ, .lfUpdate, .burstStart, .accelX, .accelY, .accelZ, .tempC, .supplyV,
    .avgX, .avgY, .avgZ, .avgMag, .queryValid, .queryKind, .querySelect, .queryTimeout,
    .queryReady, .outData, .outValid, .outReady, .captureState, .calReady, .rawReady,
    .slowCount, .slowLatest, .burstGap);
  host_model i_host (.sys_clk, .rst, .outValid, .outData, .outReady);
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  function automatic logic [31:0] u2f(input logic [15:0] v);
    int e;
    e = 15;
    if (v == 16'h0) return 32'h0;
    while (!v[e]) e--;
    return {1'b0, 8'(127 + e), 23'(32'(v) << (23 - e))};
  endfunction : u2f
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic push32(input logic [31:0] w);
    for (int b = 0; b < 4; b++) expQ.push_back(w[8*b +: 8]);
  endtask : push32
  task automatic build(input logic [1:0] sel, input int s);
    for (int p = 0; p < 2; p++) if (sel[p]) begin
      push32(probeDefined[p] ? ifSerial[p] : 32'h0);
      push32(probeDefined[p] && probeUp[p] ? probeSerial[p] : 32'h0);
      push32(probeDefined[p] && probeUp[p] ? 32'(s) : 32'h0);
      if (probeDefined[p] && probeUp[p])
        for (int k = 0; k < 8; k++) for (int j = 0; j < s; j++) push32(series[k][j]);
    end
    expQ.push_front(8'(expQ.size()));
  endtask : build
  task automatic query(input query_t k, input logic [1:0] sel, input logic [7:0] tmo);
    int i;
    queryKind = k;
    querySelect = sel;
    queryTimeout = tmo;
    queryValid = 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (queryReady !== 1'b1 && i < 50);
    #1;
    queryValid = 1'b0;
    expQ.push_back(8'h0d);
    expQ.push_back(8'h0a);
    for (i = 0; i < 3000 && i_host.rx.size() < expQ.size(); i++) tick(1);
    tick(8);
    check("reply length", i_host.rx.size(), expQ.size());
    while (expQ.size() > 0 && i_host.rx.size() > 0)
      check("reply byte", i_host.rx.pop_front(), expQ.pop_front());
    i_host.rx.delete();
    expQ.delete();
    if (i >= 3000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : query
  // ****
  // stimulus
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    lfsr = 32'd22237;
    n_mismatch = 0;
    compares = 0;
    ind = 1'b0;
    rst = 1'b1;
    {sampleValid, lfUpdate, burstStart, queryValid} = 4'h0;
    {cmdArm, cmdClear, cmdTrigger, sampleProbe} = 7'h0;
    opMode = 3'h2;
    frameLength = 4'(LEN);
    probeDefined = 2'b01;
    probeUp = 2'b11;
    calValid = 2'b11;
    ifSerial = {rnd(), rnd()};
    probeSerial = {rnd(), rnd()};
    {avgX, avgY, avgZ, avgMag} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    {fieldX, fieldY, fieldZ, fieldMag, rssiX, rssiY, rssiZ} = '0;
    {accelX, accelY, accelZ, tempC, supplyV} = {rnd(), rnd(), rnd(), rnd(), rnd()};
    queryKind = Q_BINARY;
    querySelect = 2'b00;
    queryTimeout = 8'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check("ready", queryReady, 1'b1);
    check("valid", outValid, 1'b0);
    check("state", captureState, 4'h0);
    for (int m = 0; m < 8; m++) begin
      opMode = 3'(m);
      tick(2);
      check("gap", burstGap, m inside {1, 5} ? GL : m inside {0, 2, 3} ? 0 : GS);
    end
    opMode = 3'h2;
    cmdArm = 2'b01;
    tick(1);
    cmdArm = 2'b00;
    tick(3);
    check("armed", captureState[0], CAP_ARMED);
    cmdTrigger = 2'b01;
    tick(1);
    cmdTrigger = 2'b00;
    tick(2);
    check("triggered", captureState[0], CAP_TRIGGERED);
    for (int s = 0; s < LEN; s++) begin
      {fieldX, fieldY, fieldZ, fieldMag} = {rnd(), rnd(), rnd(), rnd()};
      r = rnd();
      {rssiX, rssiY, lfUpdate, burstStart} = {r[31:16], r[15:0] ^ 16'h3fff, r[3], r[6]};
      rssiZ = 16'(rnd());
      ind = ind ^ lfUpdate;
      foreach (series[k]) series[k].push_back(k == 4 ? (ind ? 32'h3f800000 : 32'h0) : k > 4 ?
        u2f(k == 5 ? rssiX : k == 6 ? rssiY : rssiZ) : k == 0 ? fieldX : k == 1 ? fieldY :
        k == 2 ? fieldZ : fieldMag);
      sampleValid = 1'b1;
      tick(1);
      sampleValid = 1'b0;
      tick(1);
    end
    tick(3);
    check("finished", captureState[0], CAP_FINISHED);
    check("calibrated", calReady, 2'b01);
    check("raw", rawReady, 2'b01);
    check("slow accel", slowLatest[0], accelX);
    check("slow volt", slowLatest[4], supplyV);
    build(2'b11, LEN);
    query(Q_BINARY, 2'b11, 8'h0);
    push32(avgX[0]);
    push32(avgY[0]);
    push32(avgZ[0]);
    push32(avgMag[0]);
    query(Q_AVERAGE, 2'b01, 8'h0);
    build(2'b01, LEN);
    query(Q_WAIT_BINARY, 2'b01, 8'h5);
    tick(4);
    check("rearmed", captureState[0], CAP_ARMED);
    repeat (4) push32(32'h7fc00000);
    query(Q_AVERAGE, 2'b01, 8'h0);
    build(2'b01, 0);
    query(Q_WAIT_BINARY, 2'b01, 8'h1);
    tick(4);
    check("no rearm", captureState[0], CAP_ARMED);
    {probeUp, calValid} = 4'b1010;
    build(2'b01, 0);
    query(Q_BINARY, 2'b01, 8'h0);
    cmdClear = 2'b01;
    tick(1);
    cmdClear = 2'b00;
    tick(3);
    check("cleared", captureState[0], CAP_IDLE);
    end_of_test();
  end
endmodule : trigger_frame_readout_tb_top
bind trigger_frame_readout trigger_frame_readout_props #(.PROBES(PROBES),
  .GAP_LONG_CYCLES(GAP_LONG_CYCLES), .GAP_SHORT_CYCLES(GAP_SHORT_CYCLES)) i_props (.sys_clk,
  .rst, .opMode, .cmdArm, .cmdClear, .queryValid, .queryKind, .queryReady, .outValid, .outData,
  .outReady, .captureState, .calReady, .rawReady, .slowCount, .burstGap);
`default_nettype wire
